/* rtl/omcs_regs.vh */
// register layout, codes and timing constants of the fuse manual command sequencer
`ifndef OMCS_REGS_VH
`define OMCS_REGS_VH
// register select codes on the local register port
`define OMCS_SEL_PWR_REC      3'h0
`define OMCS_SEL_ACCESS       3'h1
`define OMCS_SEL_TICK_DIV     3'h2
`define OMCS_SEL_TIMING       3'h3
`define OMCS_SEL_COMMAND      3'h4
`define OMCS_SEL_STATUS       3'h5
// reset values
`define OMCS_RST_TRESR        7'h1d
`define OMCS_RST_TPSR         9'h12c
`define OMCS_RST_ACCESS       8'h00
`define OMCS_RST_TICK_DIV     8'h77
`define OMCS_RST_TPULSE       18'h00006
`define OMCS_RST_TRECOVERY    10'h007
`define OMCS_RST_THOLD        2'h0
`define OMCS_RST_TSETUP       2'h0
`define OMCS_RST_COMMAND      8'h00
`define OMCS_RST_STAGES       4'h0
`define OMCS_RST_CMD_CODE     4'h0
// field positions
`define OMCS_TRESR_HI         15
`define OMCS_TRESR_LO         9
`define OMCS_TPSR_HI          8
`define OMCS_TPSR_LO          0
`define OMCS_TPULSE_HI        31
`define OMCS_TPULSE_LO        14
`define OMCS_TREC_HI          13
`define OMCS_TREC_LO          4
`define OMCS_THOLD_HI         3
`define OMCS_THOLD_LO         2
`define OMCS_TSETUP_HI        1
`define OMCS_TSETUP_LO        0
`define OMCS_STAGES_HI        7
`define OMCS_STAGES_LO        4
`define OMCS_CMD_HI           3
`define OMCS_CMD_LO           0
`define OMCS_STG_SETUP        3
`define OMCS_STG_PULSE        2
`define OMCS_STG_HOLD         1
`define OMCS_STG_RECOVERY     0
// unlock key
`define OMCS_UNLOCK_KEY       8'h97
// command codes
`define OMCS_CMD_NOP          4'h0
`define OMCS_CMD_RESET        4'h1
`define OMCS_CMD_POWER_UP     4'h4
`define OMCS_CMD_POWER_DOWN   4'h5
`define OMCS_CMD_READ         4'h6
`define OMCS_CMD_WRITE        4'h7
`define OMCS_CMD_PROGRAM      4'h8
`define OMCS_CMD_COMPARE      4'h9
`define OMCS_CMD_PRECHARGE    4'ha
`define OMCS_CMD_AUX_UPDATE   4'hb
`define OMCS_CMD_WAIT         4'hd
`define OMCS_CMD_PGM_ASSIST   4'he
// reset recovery unit is four system clocks
`define OMCS_TRESR_UNIT_LOG2  2
`endif

/* rtl/omcs_us_tick.v */
// microsecond tick generator from the programmed divider
`include "omcs_regs.vh"
module omcs_us_tick (
   // clock and reset
   input  wire       clock,
   input  wire       sys_rst,
   input  wire       clk_en,
   // divider and tick
   input  wire [7:0] microsecond_divider,
   output reg        us_tick
);
   reg [7:0] cnt_r;

   // counts divider+1 cycles per tick
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r   <= 8'h00;
         us_tick <= 1'b0;
      end else if (clk_en) begin
         if (cnt_r >= microsecond_divider) begin
            cnt_r   <= 8'h00;
            us_tick <= 1'b1;
         end else begin
            cnt_r   <= cnt_r + 8'h01;
            us_tick <= 1'b0;
         end
      end
   end
endmodule // omcs_us_tick

/* rtl/omcs_phase_timer.v */
// loadable down counter that marks the last cycle of a phase
`include "omcs_regs.vh"
module omcs_phase_timer (
   // clock and reset
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        clk_en,
   // control
   input  wire        load,
   input  wire [17:0] load_val,
   input  wire        step,
   // status
   output wire        expired
);
   reg [17:0] cnt_r;

   assign expired = (cnt_r == 18'h00000);

   // load value is the phase length minus one
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 18'h00000;
      end else if (clk_en) begin
         if (load) begin
            cnt_r <= load_val;
         end else if (step && !expired) begin
            cnt_r <= cnt_r - 18'h00001;
         end
      end
   end
endmodule // omcs_phase_timer

/* rtl/omcs_sequencer.v */
// fuse memory manual command sequencer: registers, phase engine and macro strobes
`include "omcs_regs.vh"
module omcs_sequencer (
   // clock, reset, enable
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        clk_en,
   // register port
   input  wire [2:0]  reg_sel,
   input  wire        reg_wr,
   input  wire [31:0] reg_wdata,
   output reg  [31:0] reg_rdata,
   // memory enable from control register
   input  wire        mem_enable,
   // memory macro strobes
   output reg  [3:0]  mem_cmd,
   output reg         mem_setup,
   output reg         mem_pulse,
   output reg         mem_hold,
   output reg         mem_recovery,
   // programming assist handoff
   output reg         assist_start,
   input  wire        assist_busy,
   // status
   output wire        seq_busy
);
   localparam [2:0] ST_IDLE     = 3'h0;
   localparam [2:0] ST_SETUP    = 3'h1;
   localparam [2:0] ST_PULSE    = 3'h2;
   localparam [2:0] ST_HOLD     = 3'h3;
   localparam [2:0] ST_RECOVERY = 3'h4;
   localparam [2:0] ST_RST_WAIT = 3'h5;
   localparam [2:0] ST_PWR_WAIT = 3'h6;
   localparam [2:0] ST_ASSIST   = 3'h7;

   // registers
   reg [6:0]  tresr_r;
   reg [8:0]  tpsr_r;
   reg [7:0]  access_r;
   reg [7:0]  tick_div_r;
   reg [17:0] tpulse_r;
   reg [9:0]  trecovery_r;
   reg [1:0]  thold_r;
   reg [1:0]  tsetup_r;
   reg [3:0]  stages_r;
   reg [3:0]  cmd_r;
   reg        start_r;

   // engine
   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [3:0]  run_stages_r;
   reg [3:0]  run_cmd_r;
   reg        tmr_load;
   reg [17:0] tmr_val;
   reg        tmr_step;
   wire       tmr_expired;
   wire       us_tick;

   wire unlocked = (access_r == `OMCS_UNLOCK_KEY);
   wire cmd_write = reg_wr && (reg_sel == `OMCS_SEL_COMMAND);

   assign seq_busy = (state_r != ST_IDLE) || start_r;

   omcs_us_tick u_tick (
      .clock               (clock),
      .sys_rst             (sys_rst),
      .clk_en              (clk_en),
      .microsecond_divider (tick_div_r),
      .us_tick             (us_tick)
   );

   omcs_phase_timer u_timer (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .load     (tmr_load),
      .load_val (tmr_val),
      .step     (tmr_step),
      .expired  (tmr_expired)
   );

   // register writes
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tresr_r     <= `OMCS_RST_TRESR;
         tpsr_r      <= `OMCS_RST_TPSR;
         access_r    <= `OMCS_RST_ACCESS;
         tick_div_r  <= `OMCS_RST_TICK_DIV;
         tpulse_r    <= `OMCS_RST_TPULSE;
         trecovery_r <= `OMCS_RST_TRECOVERY;
         thold_r     <= `OMCS_RST_THOLD;
         tsetup_r    <= `OMCS_RST_TSETUP;
         stages_r    <= `OMCS_RST_STAGES;
         cmd_r       <= `OMCS_RST_CMD_CODE;
         start_r     <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ST_IDLE) begin
            start_r <= 1'b0;
         end
         if (reg_wr) begin
            if (reg_sel == `OMCS_SEL_PWR_REC) begin
               tresr_r <= reg_wdata[`OMCS_TRESR_HI:`OMCS_TRESR_LO];
               tpsr_r  <= reg_wdata[`OMCS_TPSR_HI:`OMCS_TPSR_LO];
            end else if (reg_sel == `OMCS_SEL_ACCESS) begin
               access_r <= reg_wdata[7:0];
            end else if (reg_sel == `OMCS_SEL_TICK_DIV) begin
               tick_div_r <= reg_wdata[7:0];
            end else if (reg_sel == `OMCS_SEL_TIMING) begin
               tpulse_r    <= reg_wdata[`OMCS_TPULSE_HI:`OMCS_TPULSE_LO];
               trecovery_r <= reg_wdata[`OMCS_TREC_HI:`OMCS_TREC_LO];
               thold_r     <= reg_wdata[`OMCS_THOLD_HI:`OMCS_THOLD_LO];
               tsetup_r    <= reg_wdata[`OMCS_TSETUP_HI:`OMCS_TSETUP_LO];
            end else if (reg_sel == `OMCS_SEL_COMMAND) begin
               stages_r <= reg_wdata[`OMCS_STAGES_HI:`OMCS_STAGES_LO];
               cmd_r    <= reg_wdata[`OMCS_CMD_HI:`OMCS_CMD_LO];
            end
         end
         // writes while busy or locked store the value but start nothing
         if (cmd_write && unlocked && state_r == ST_IDLE && !start_r) begin
            start_r <= 1'b1;
         end
      end
   end

   // register reads
   always @* begin
      reg_rdata = 32'h00000000;
      if (reg_sel == `OMCS_SEL_PWR_REC) begin
         reg_rdata[`OMCS_TRESR_HI:`OMCS_TRESR_LO] = tresr_r;
         reg_rdata[`OMCS_TPSR_HI:`OMCS_TPSR_LO]   = tpsr_r;
      end else if (reg_sel == `OMCS_SEL_ACCESS) begin
         reg_rdata[7:0] = access_r;
      end else if (reg_sel == `OMCS_SEL_TICK_DIV) begin
         reg_rdata[7:0] = tick_div_r;
      end else if (reg_sel == `OMCS_SEL_TIMING) begin
         reg_rdata[`OMCS_TPULSE_HI:`OMCS_TPULSE_LO] = tpulse_r;
         reg_rdata[`OMCS_TREC_HI:`OMCS_TREC_LO]     = trecovery_r;
         reg_rdata[`OMCS_THOLD_HI:`OMCS_THOLD_LO]   = thold_r;
         reg_rdata[`OMCS_TSETUP_HI:`OMCS_TSETUP_LO] = tsetup_r;
      end else if (reg_sel == `OMCS_SEL_COMMAND) begin
         reg_rdata[`OMCS_STAGES_HI:`OMCS_STAGES_LO] = stages_r;
         reg_rdata[`OMCS_CMD_HI:`OMCS_CMD_LO]       = cmd_r;
      end else if (reg_sel == `OMCS_SEL_STATUS) begin
         reg_rdata[2:0] = state_r;
         reg_rdata[3]   = seq_busy;
         reg_rdata[4]   = unlocked;
      end
   end

   // first enabled phase at or after a given position, in fixed order
   function [2:0] next_phase;
      input [3:0] stg;
      input [2:0] from;
      begin
         if (from <= ST_SETUP && stg[`OMCS_STG_SETUP]) begin
            next_phase = ST_SETUP;
         end else if (from <= ST_PULSE && stg[`OMCS_STG_PULSE]) begin
            next_phase = ST_PULSE;
         end else if (from <= ST_HOLD && stg[`OMCS_STG_HOLD]) begin
            next_phase = ST_HOLD;
         end else if (from <= ST_RECOVERY && stg[`OMCS_STG_RECOVERY]) begin
            next_phase = ST_RECOVERY;
         end else begin
            next_phase = ST_IDLE;
         end
      end
   endfunction

   // phase length minus one for a state
   function [17:0] phase_len;
      input [2:0] st;
      begin
         if (st == ST_SETUP) begin
            phase_len = {16'h0000, tsetup_r};
         end else if (st == ST_PULSE) begin
            phase_len = tpulse_r;
         end else if (st == ST_HOLD) begin
            phase_len = {16'h0000, thold_r};
         end else if (st == ST_RECOVERY) begin
            phase_len = {8'h00, trecovery_r};
         end else begin
            phase_len = 18'h00000;
         end
      end
   endfunction

   // where a finished command goes: reset and power-up add a recovery wait
   function [2:0] after_cmd;
      input [3:0] c;
      begin
         if (c == `OMCS_CMD_RESET) begin
            after_cmd = ST_RST_WAIT;
         end else if (c == `OMCS_CMD_POWER_UP) begin
            after_cmd = ST_PWR_WAIT;
         end else begin
            after_cmd = ST_IDLE;
         end
      end
   endfunction

   reg [2:0] nph;
   always @* begin
      state_nxt = state_r;
      tmr_load  = 1'b0;
      tmr_val   = 18'h00000;
      tmr_step  = 1'b1;
      nph       = ST_IDLE;
      case (state_r)
         ST_IDLE: begin
            if (start_r) begin
               if (cmd_r == `OMCS_CMD_PGM_ASSIST) begin
                  state_nxt = ST_ASSIST;
               end else begin
                  nph = next_phase(stages_r, ST_SETUP);
                  if (nph == ST_IDLE) begin
                     state_nxt = after_cmd(cmd_r);
                  end else begin
                     state_nxt = nph;
                  end
                  tmr_load = 1'b1;
                  if (nph == ST_IDLE && cmd_r == `OMCS_CMD_RESET) begin
                     tmr_val = {9'h000, tresr_r, 2'h3};
                  end else if (nph == ST_IDLE && cmd_r == `OMCS_CMD_POWER_UP) begin
                     tmr_val = {9'h000, tpsr_r};
                  end else begin
                     tmr_val = phase_len(nph);
                  end
               end
            end
         end
         ST_SETUP, ST_PULSE, ST_HOLD, ST_RECOVERY: begin
            if (tmr_expired) begin
               nph = next_phase(run_stages_r, state_r + 3'h1);
               if (nph == ST_IDLE) begin
                  state_nxt = after_cmd(run_cmd_r);
               end else begin
                  state_nxt = nph;
               end
               tmr_load = 1'b1;
               if (nph == ST_IDLE && run_cmd_r == `OMCS_CMD_RESET) begin
                  // (tresr+1)*4 cycles, loaded as count minus one
                  tmr_val = {9'h000, tresr_r, 2'h3};
               end else if (nph == ST_IDLE && run_cmd_r == `OMCS_CMD_POWER_UP) begin
                  tmr_val = {9'h000, tpsr_r};
               end else begin
                  tmr_val = phase_len(nph);
               end
            end
         end
         ST_RST_WAIT: begin
            if (tmr_expired) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PWR_WAIT: begin
            // counted in microsecond ticks, one extra tick covers the partial first
            tmr_step = us_tick;
            if (tmr_expired && us_tick) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_ASSIST: begin
            // no phase timings are passed to the assist engine; back to idle once assist_busy is low after the start pulse
            if (!assist_busy && !assist_start) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r      <= ST_IDLE;
         run_stages_r <= 4'h0;
         run_cmd_r    <= `OMCS_CMD_NOP;
         assist_start <= 1'b0;
      end else if (clk_en) begin
         state_r      <= state_nxt;
         assist_start <= (state_r == ST_IDLE) && (state_nxt == ST_ASSIST);
         if (state_r == ST_IDLE && start_r) begin
            run_stages_r <= stages_r;
            run_cmd_r    <= cmd_r;
         end
      end
   end

   // macro strobes; wait and no-op keep every input inactive
   // run_cmd_r still holds the previous command on the edge that enters the first phase
   wire [3:0] eff_cmd   = run_cmd_nxt_sel(state_r, cmd_r, run_cmd_r);
   wire       strobe_ok = mem_enable && (eff_cmd != `OMCS_CMD_WAIT) && (eff_cmd != `OMCS_CMD_NOP);
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_cmd      <= `OMCS_CMD_NOP;
         mem_setup    <= 1'b0;
         mem_pulse    <= 1'b0;
         mem_hold     <= 1'b0;
         mem_recovery <= 1'b0;
      end else if (clk_en) begin
         mem_cmd      <= (strobe_ok && state_nxt >= ST_SETUP && state_nxt <= ST_RECOVERY) ?
                         run_cmd_nxt_sel(state_r, cmd_r, run_cmd_r) : `OMCS_CMD_NOP;
         mem_setup    <= strobe_ok && (state_nxt == ST_SETUP);
         mem_pulse    <= strobe_ok && (state_nxt == ST_PULSE);
         mem_hold     <= strobe_ok && (state_nxt == ST_HOLD);
         mem_recovery <= strobe_ok && (state_nxt == ST_RECOVERY);
      end
   end

   // command seen by the macro: the one latched this cycle when leaving idle
   function [3:0] run_cmd_nxt_sel;
      input [2:0] st;
      input [3:0] c_new;
      input [3:0] c_run;
      begin
         run_cmd_nxt_sel = (st == ST_IDLE) ? c_new : c_run;
      end
   endfunction
endmodule // omcs_sequencer

/* sim/omcs_sequencer_assertions.sv */
// port assertions for the fuse manual command sequencer
`include "omcs_regs.vh"
module omcs_sequencer_checker (
   // clock and reset
   input wire        clock,
   input wire        sys_rst,
   input wire        clk_en,
   // register port
   input wire [2:0]  reg_sel,
   input wire        reg_wr,
   input wire [31:0] reg_wdata,
   // macro side
   input wire [3:0]  mem_cmd,
   input wire        mem_setup,
   input wire        mem_pulse,
   input wire        mem_hold,
   input wire        mem_recovery,
   input wire        assist_start,
   input wire        seq_busy
);
   reg  [7:0]  key_r;
   reg  [3:0]  cmd_r;
   reg  [31:0] tim_r;
   reg  [6:0]  tresr_r;
   reg  [17:0] cs_r, cp_r, ch_r, cr_r;
   reg  [9:0]  gap_r;
   wire        wr_cmd = reg_wr && clk_en && reg_sel == `OMCS_SEL_COMMAND;
   wire        ok = key_r == `OMCS_UNLOCK_KEY && !seq_busy;
   wire        any = mem_setup || mem_pulse || mem_hold || mem_recovery;
   // shadows follow software writes so lengths are judged against live settings
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         key_r <= `OMCS_RST_ACCESS;
         cmd_r <= `OMCS_CMD_NOP;
         tim_r <= {`OMCS_RST_TPULSE, `OMCS_RST_TRECOVERY, `OMCS_RST_THOLD, `OMCS_RST_TSETUP};
         tresr_r <= `OMCS_RST_TRESR;
         cs_r <= 18'h0;
         cp_r <= 18'h0;
         ch_r <= 18'h0;
         cr_r <= 18'h0;
         gap_r <= 10'h0;
      end else if (clk_en) begin
         if (reg_wr && reg_sel == `OMCS_SEL_ACCESS) key_r <= reg_wdata[7:0];
         if (reg_wr && reg_sel == `OMCS_SEL_TIMING) tim_r <= reg_wdata;
         if (reg_wr && reg_sel == `OMCS_SEL_PWR_REC) tresr_r <= reg_wdata[15:9];
         if (wr_cmd && ok) cmd_r <= reg_wdata[3:0];
         cs_r <= mem_setup ? cs_r + 18'h1 : 18'h0;
         cp_r <= mem_pulse ? cp_r + 18'h1 : 18'h0;
         ch_r <= mem_hold ? ch_r + 18'h1 : 18'h0;
         cr_r <= mem_recovery ? cr_r + 18'h1 : 18'h0;
         gap_r <= !seq_busy ? 10'h0 : gap_r + {9'h0, !any};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_assist_req;
      wr_cmd && ok && reg_wdata[3:0] == `OMCS_CMD_PGM_ASSIST;
   endsequence
   sequence s_phase_end;
      $fell(mem_pulse) || $fell(mem_hold) || $fell(mem_recovery);
   endsequence
   property p_locked;
      wr_cmd && key_r != `OMCS_UNLOCK_KEY && !seq_busy |=> !seq_busy;
   endproperty
   a_locked: assert property (p_locked) else $error("locked command started");
   property p_setup_len;
      $fell(mem_setup) |-> cs_r == tim_r[1:0] + 1;
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("setup length wrong");
   property p_pulse_len;
      $fell(mem_pulse) |-> cp_r == tim_r[31:14] + 1;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
   property p_hold_len;
      $fell(mem_hold) |-> ch_r == tim_r[3:2] + 1;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
   property p_rec_len;
      $fell(mem_recovery) |-> cr_r == tim_r[13:4] + 1;
   endproperty
   a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
   property p_order;
      s_phase_end |-> !mem_setup && !(mem_pulse && $past(mem_hold || mem_recovery));
   endproperty
   a_order: assert property (p_order) else $error("phase order broken");
   property p_quiet;
      seq_busy && (cmd_r == `OMCS_CMD_WAIT || cmd_r == `OMCS_CMD_NOP) |-> !any && mem_cmd == 4'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("macro touched by quiet command");
   property p_assist;
      s_assist_req |-> ##[1:3] assist_start ##1 !assist_start;
   endproperty
   a_assist: assert property (p_assist) else $error("assist start missing");
   property p_reset_rec;
      $fell(seq_busy) && cmd_r == `OMCS_CMD_RESET |-> gap_r >= 4 * tresr_r + 4 && gap_r <= 4 * tresr_r + 6;
   endproperty
   a_reset_rec: assert property (p_reset_rec) else $error("reset recovery wrong");
endmodule // omcs_sequencer_checker
bind omcs_sequencer omcs_sequencer_checker u_chk (.clock, .sys_rst, .clk_en, .reg_sel, .reg_wr, .reg_wdata,
   .mem_cmd, .mem_setup, .mem_pulse, .mem_hold, .mem_recovery, .assist_start, .seq_busy);

/* sim/omcs_fuse_macro_model.sv */
// behavioural programming assist engine on the fuse macro side
module omcs_fuse_macro_model #(
   parameter ASSIST_CYCLES = 6
) (
   // clock and reset
   input  wire clock,
   input  wire sys_rst,
   // assist handshake
   input  wire assist_start,
   output wire assist_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   integer cnt_r;
   // busy for a fixed span so the sequencer has to hold off
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) cnt_r <= 0;
      else if (assist_start) cnt_r <= ASSIST_CYCLES;
      else if (cnt_r != 0) cnt_r <= cnt_r - 1;
   end
   assign assist_busy = cnt_r != 0;
endmodule // omcs_fuse_macro_model

/* sim/omcs_sequencer_tb.sv */
// self-checking bench for the fuse manual command sequencer
`include "omcs_regs.vh"
module omcs_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam TRESR = 2, TPSR = 4, DIV = 2;
   logic        clock, sys_rst, clk_en, reg_wr, mem_enable, mem_setup, mem_pulse, mem_hold, mem_recovery;
   logic        assist_start, assist_busy, seq_busy;
   logic [2:0]  reg_sel;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0]  mem_cmd, seen, ps, stb;
   logic [15:0] ord;
   int          n[4], nb, na, err_count, comparisons, r;
   logic [7:0]  cmds [12] = '{8'h51, 8'h44, 8'h45, 8'hd6, 8'hd7, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h4d, 8'h00, 8'hf6};
   logic [31:0] tims [12];
   omcs_sequencer u_dut (.clock, .sys_rst, .clk_en, .reg_sel, .reg_wr, .reg_wdata, .reg_rdata, .mem_enable,
      .mem_cmd, .mem_setup, .mem_pulse, .mem_hold, .mem_recovery, .assist_start, .assist_busy, .seq_busy);
   omcs_fuse_macro_model u_macro (.clock, .sys_rst, .assist_start, .assist_busy);
   assign stb = {mem_setup, mem_pulse, mem_hold, mem_recovery};
   always #20 clock = ~clock;
   always @(posedge clock) if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
         if (stb[3-i]) begin
            n[i]++;
            if (!ps[3-i]) ord = {ord[11:0], 4'(i + 1)};
         end
      end
      ps = stb;
      nb += seq_busy;
      na += assist_start;
      if (mem_pulse) seen = mem_cmd;
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [31:0] d);
      @(posedge clock);
      reg_sel <= s;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [31:0] exp);
      @(posedge clock);
      reg_sel <= s;
      #1 chk("register read", exp, reg_rdata);
   endtask
   task automatic go(input logic [7:0] c);
      n = '{0, 0, 0, 0};
      {nb, na, ord, seen} = '0;
      wr(`OMCS_SEL_COMMAND, {24'h0, c});
   endtask
   task automatic fin;
      for (int k = 0; k <= 3000; k++) begin
         if (k == 3000) begin
            $display("FAIL busy wait expected 0 seen 1");
            err_count++;
            conclude();
         end
         @(posedge clock);
         #1 if (seq_busy !== 1'b1) break;
      end
   endtask
   task automatic check_run(input logic [7:0] c, input logic [31:0] t);
      int d[4], e[4], sum, extra;
      logic [15:0] eo;
      d[0] = c[7] ? t[1:0] + 1 : 0;
      d[1] = c[6] ? t[31:14] + 1 : 0;
      d[2] = c[5] ? t[3:2] + 1 : 0;
      d[3] = c[4] ? t[13:4] + 1 : 0;
      {sum, eo} = '0;
      extra = c[3:0] == `OMCS_CMD_RESET ? 4 * (TRESR + 1) : c[3:0] == `OMCS_CMD_POWER_UP ? TPSR * (DIV + 1) : 0;
      for (int i = 0; i < 4; i++) begin
         e[i] = (c[3:0] == `OMCS_CMD_NOP || c[3:0] == `OMCS_CMD_WAIT) ? 0 : d[i];
         sum += d[i];
         if (e[i] != 0) eo = {eo[11:0], 4'(i + 1)};
      end
      chk("setup cycles", e[0], n[0]);
      chk("pulse cycles", e[1], n[1]);
      chk("hold cycles", e[2], n[2]);
      chk("recovery cycles", e[3], n[3]);
      chk("phase order", eo, ord);
      if (e[1] != 0) chk("macro command", c[3:0], seen);
      chk("busy span", 1, (nb - sum - extra) inside {[0:5]});
   endtask
   initial begin
      tims = '{0: 32'h0001c070, 1: 32'h0000400e, 2: 32'h00003ff0, 3: 32'h0000400e, 4: 32'h0001c070,
         5: 32'h0000400e, 6: 32'h0001c070, 7: 32'h0000400e, 8: 32'h0001c070, 9: 32'h0000400e,
         10: 32'h0001c070, 11: 32'h0000400e};
      {clock, reg_sel, reg_wr, reg_wdata, mem_enable, ps, comparisons, err_count} = '0;
      {sys_rst, clk_en} = 2'b11;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      mem_enable <= 1'b1;
      wr(`OMCS_SEL_ACCESS, 32'h97);
      wr(`OMCS_SEL_PWR_REC, (TRESR << 9) | TPSR);
      wr(`OMCS_SEL_TICK_DIV, DIV);
      for (r = 0; r < 12; r++) begin
         wr(`OMCS_SEL_TIMING, tims[r]);
         go(cmds[r]);
         fin();
         check_run(cmds[r], tims[r]);
         $display("row %0d done", r);
      end
      wr(`OMCS_SEL_TIMING, 32'h0001c070);
      go(8'hd6);
      wr(`OMCS_SEL_COMMAND, 32'h59);
      fin();
      check_run(8'hd6, 32'h0001c070);
      repeat (3) @(posedge clock);
      #1 chk("busy after refusal", 0, seq_busy);
      $display("refusal test done");
      wr(`OMCS_SEL_TIMING, 32'h0001c07c);
      go(8'hfe);
      fin();
      chk("assist starts", 1, na);
      chk("hold unused", 0, n[2]);
      chk("assist waited", 1, nb >= 6);
      rd(`OMCS_SEL_COMMAND, 32'hfe);
      rd(`OMCS_SEL_STATUS, 32'h10);
      $display("assist test done");
      @(posedge clock);
      clk_en <= 1'b0;
      go(8'hd6);
      clk_en <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk("frozen write", 0, seq_busy);
      $display("freeze test done");
      @(posedge clock);
      mem_enable <= 1'b0;
      go(8'hd6);
      fin();
      chk("strobes while disabled", 0, n[0] + n[1] + n[3]);
      $display("disable test done");
      @(posedge clock);
      mem_enable <= 1'b1;
      sys_rst <= 1'b1;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      rd(`OMCS_SEL_PWR_REC, {16'h0, 7'h1d, 9'h12c});
      rd(`OMCS_SEL_ACCESS, 32'h0);
      rd(`OMCS_SEL_TICK_DIV, 32'h77);
      rd(`OMCS_SEL_TIMING, {18'h6, 10'h7, 2'h0, 2'h0});
      rd(`OMCS_SEL_COMMAND, 32'h0);
      rd(`OMCS_SEL_STATUS, 32'h0);
      wr(3'h6, 32'hffffffff);
      rd(3'h6, 32'h0);
      go(8'hd6);
      fin();
      chk("locked busy", 0, nb);
      wr(`OMCS_SEL_ACCESS, 32'h96);
      go(8'hd6);
      fin();
      chk("wrong key busy", 0, nb);
      $display("reset and lock test done");
      conclude();
   end
endmodule // omcs_sequencer_tb
